/* File: rtl/bcs_pkg.sv */
// Purpose: Shared constants for the clock-calendar static memory.
// Assumes: 40 MHz system clock; BCD calendar bytes.
// Notes:   Cycle counts are derived from the printed times.
package bcs_pkg;
    // Bus geometry
    localparam int             BCS_ADDR_W     = 13;
    localparam int             BCS_DATA_W     = 8;
    localparam logic [12:0]    BCS_CLOCK_BASE = 13'h1FF8;
    // Clock byte indices within the top eight locations
    localparam logic [2:0]     BCS_IDX_CTRL   = 3'h0;
    localparam logic [2:0]     BCS_IDX_SEC    = 3'h1;
    localparam logic [2:0]     BCS_IDX_MIN    = 3'h2;
    localparam logic [2:0]     BCS_IDX_HOUR   = 3'h3;
    localparam logic [2:0]     BCS_IDX_DAY    = 3'h4;
    localparam logic [2:0]     BCS_IDX_DATE   = 3'h5;
    localparam logic [2:0]     BCS_IDX_MONTH  = 3'h6;
    localparam logic [2:0]     BCS_IDX_YEAR   = 3'h7;
    // Control register fields and reset value
    localparam int             BCS_CTRL_WRITE_BIT = 7;
    localparam int             BCS_CTRL_READ_BIT  = 6;
    localparam logic [7:0]     BCS_CTRL_RST   = 8'h00;
    // Calendar reset values and BCD limits
    localparam logic [7:0]     BCS_RST_SEC    = 8'h00;
    localparam logic [7:0]     BCS_RST_MIN    = 8'h00;
    localparam logic [7:0]     BCS_RST_HOUR   = 8'h00;
    localparam logic [7:0]     BCS_RST_DAY    = 8'h01;
    localparam logic [7:0]     BCS_RST_DATE   = 8'h01;
    localparam logic [7:0]     BCS_RST_MONTH  = 8'h01;
    localparam logic [7:0]     BCS_RST_YEAR   = 8'h00;
    localparam logic [7:0]     BCS_MAX_SEC    = 8'h59;
    localparam logic [7:0]     BCS_MAX_HOUR   = 8'h23;
    localparam logic [7:0]     BCS_MAX_DAY    = 8'h07;
    localparam logic [7:0]     BCS_MAX_MONTH  = 8'h12;
    localparam logic [7:0]     BCS_MAX_YEAR   = 8'h99;
    // Value shown on the data lines while read data is not yet valid
    localparam logic [7:0]     BCS_INDET_DATA = 8'hA5;
    // Times in ns and their cycle counts
    localparam int             BCS_CLK_NS     = 25;
    localparam int             BCS_ADDR_ACC_NS = 100;
    localparam int             BCS_SEL_ACC_NS = 100;
    localparam int             BCS_OE_ACC_NS  = 50;
    localparam int             BCS_HOLD_NS    = 5;
    localparam int             BCS_SECOND_NS  = 1000000000;
    localparam int BCS_ADDR_CYC = (BCS_ADDR_ACC_NS + BCS_CLK_NS - 1)
                                  / BCS_CLK_NS;
    localparam int BCS_SEL_CYC  = (BCS_SEL_ACC_NS + BCS_CLK_NS - 1)
                                  / BCS_CLK_NS;
    localparam int BCS_OE_CYC   = (BCS_OE_ACC_NS + BCS_CLK_NS - 1)
                                  / BCS_CLK_NS;
    localparam int BCS_HOLD_CYC = (BCS_HOLD_NS + BCS_CLK_NS - 1) / BCS_CLK_NS;
    localparam int BCS_SECOND_CYCLES = BCS_SECOND_NS / BCS_CLK_NS;
endpackage

/* File: rtl/bcs_calendar.sv */
// Purpose: Live BCD time counters advanced once per second tick.
// Assumes: Loaded values are legal BCD; leap years valid until 2100.
// Notes:   Runs regardless of supply state so time keeps on battery.
module bcs_calendar (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       tick,
    input  wire logic       load,
    // Values to load
    input  wire logic [7:0] ld_sec,
    input  wire logic [7:0] ld_min,
    input  wire logic [7:0] ld_hour,
    input  wire logic [7:0] ld_day,
    input  wire logic [7:0] ld_date,
    input  wire logic [7:0] ld_month,
    input  wire logic [7:0] ld_year,
    // Current time
    output logic      [7:0] sec,
    output logic      [7:0] min,
    output logic      [7:0] hour,
    output logic      [7:0] day,
    output logic      [7:0] date,
    output logic      [7:0] month,
    output logic      [7:0] year
);
    import bcs_pkg::*;

    // BCD increment of a two-digit value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // Leap year and month length, all in BCD
    wire       leap   = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                                : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                                   year[3:0] == 4'h8);
    wire [7:0] dim    = (month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                        (month == 8'h04 || month == 8'h06 ||
                         month == 8'h09 || month == 8'h11) ? 8'h30 : 8'h31;
    // Carry chain
    wire       c_min  = sec == BCS_MAX_SEC;
    wire       c_hour = c_min && min == BCS_MAX_SEC;
    wire       c_day  = c_hour && hour == BCS_MAX_HOUR;
    wire       c_mon  = c_day && date == dim;
    wire       c_year = c_mon && month == BCS_MAX_MONTH;

    // Counter update: load takes precedence over the tick
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sec   <= BCS_RST_SEC;
            min   <= BCS_RST_MIN;
            hour  <= BCS_RST_HOUR;
            day   <= BCS_RST_DAY;
            date  <= BCS_RST_DATE;
            month <= BCS_RST_MONTH;
            year  <= BCS_RST_YEAR;
        end else if (load) begin
            sec   <= ld_sec;
            min   <= ld_min;
            hour  <= ld_hour;
            day   <= ld_day;
            date  <= ld_date;
            month <= ld_month;
            year  <= ld_year;
        end else if (tick) begin
            sec <= c_min ? 8'h00 : bcd_inc(sec);
            if (c_min) min <= c_hour ? 8'h00 : bcd_inc(min);
            if (c_hour) hour <= c_day ? 8'h00 : bcd_inc(hour);
            if (c_day) day <= (day == BCS_MAX_DAY) ? 8'h01 : bcd_inc(day);
            if (c_day) date <= c_mon ? 8'h01 : bcd_inc(date);
            if (c_mon) month <= c_year ? 8'h01 : bcd_inc(month);
            if (c_year) year <= (year == BCS_MAX_YEAR) ? 8'h00
                                                       : bcd_inc(year);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sec_wrap: assert property (tick && !load && sec == 8'h59 |=>
        sec == 8'h00 && min == $past(bcd_inc(min)) || $past(c_hour))
        else $error("seconds did not wrap to zero");
    a_day_wrap: assert property (tick && !load && c_day |=>
        hour == 8'h00 && min == 8'h00)
        else $error("24 hour rollover failed");
    a_feb_roll: assert property (tick && !load && c_day &&
        month == 8'h02 && date == 8'h28 && !leap |=>
        date == 8'h01 && month == 8'h03)
        else $error("february end of month rollover failed");
    a_leap_day: assert property (tick && !load && c_day &&
        month == 8'h02 && date == 8'h28 && leap |=> date == 8'h29)
        else $error("leap day skipped");
    a_year_roll: assert property (tick && !load && c_year &&
        year != BCS_MAX_YEAR |=> year == $past(bcd_inc(year)) &&
        month == 8'h01)
        else $error("year did not advance at new year");
endmodule

/* File: rtl/bcs_clock_sram.sv */
// Purpose: 8K x 8 static memory with a BCD calendar in the top bytes.
// Assumes: Bus inputs are synchronous to clk; supply flags from a monitor.
// Notes:   Two-way data lines are split into in, out and output enable.
//
// Contract
// - Clock bytes occupy top eight memory locations
// - BCD calendar fields, hours on 24 scale
// - Month lengths and leap years roll automatically
// - Lowest clock byte is control and calibration
// - Clock bytes are cells refreshed each second
// - Clock bytes use the normal memory protocol
// - Out-of-tolerance supply blocks every write
// - Battery keeps data and clock counting
// - Data lines driven only when selected, enabled
// - Read when write enable high, both selected
// - Thirteen address lines pick one byte
// - Data valid after latest of access times
// - Early enable shows indeterminate data first
// - Address change keeps old data for hold
// - Write while write enable and selects active
// - Power-fail window deselects, floats, ignores inputs
module bcs_clock_sram #(
    parameter int SECOND_CYCLES = bcs_pkg::BCS_SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    // Host memory bus
    input  wire logic [bcs_pkg::BCS_ADDR_W-1:0]    addr,
    input  wire logic                              select_active_low_n,
    input  wire logic                              select_active_high,
    input  wire logic                              output_enable_n,
    input  wire logic                              write_enable_n,
    input  wire logic [bcs_pkg::BCS_DATA_W-1:0]    data_io_in,
    output logic      [bcs_pkg::BCS_DATA_W-1:0]    data_io_out,
    output logic                                   data_io_oe,
    output logic                                   data_io_valid,
    // Supply monitor
    input  wire logic                              supply_ok,
    input  wire logic                              on_battery,
    output logic                                   deselected
);
    import bcs_pkg::*;

    localparam int PW = $clog2(SECOND_CYCLES + 1);

    logic [7:0]            mem [0:(1 << BCS_ADDR_W) - 1];
    logic [7:0]            clock_cells [0:7];
    logic [7:0]            cal_now [1:7];
    logic [PW-1:0]         presc;
    logic                  tick_q;
    logic                  ctrl_write_q;
    logic [BCS_ADDR_W-1:0] prev_addr;
    logic [2:0]            age_ok;
    logic [1:0]            hold_cnt;

    // Access qualification; power fail masks both selects, so no read or write is accepted
    wire       pf        = !supply_ok || on_battery;
    wire       sel_on    = !select_active_low_n && select_active_high && !pf;
    wire       rd_en     = sel_on && write_enable_n && !output_enable_n;
    wire       wr_en     = sel_on && !write_enable_n;
    wire       clock_sel = addr >= BCS_CLOCK_BASE;
    wire [2:0] cidx      = addr[2:0];
    wire [7:0] rd_data   = clock_sel ? clock_cells[cidx] : mem[addr];
    wire       addr_chg  = addr != prev_addr;
    wire [2:0] restart   = {output_enable_n, !sel_on, addr_chg};
    wire       all_ok    = &age_ok;
    wire       hold_now  = (addr_chg && data_io_valid) || hold_cnt != 2'h0;
    wire [7:0] next_data = all_ok ? rd_data :
                           hold_now ? data_io_out : BCS_INDET_DATA;
    // Control register fields
    wire [7:0] clock_control_calibration = clock_cells[BCS_IDX_CTRL];
    wire       write_hold = clock_control_calibration[BCS_CTRL_WRITE_BIT];
    wire       read_hold  = clock_control_calibration[BCS_CTRL_READ_BIT];
    wire       cal_load   = ctrl_write_q && !write_hold;
    // A load edge keeps the freshly written cells instead of stale time
    wire       refresh    = tick_q && !write_hold && !read_hold &&
                            !cal_load;
    wire       tick       = presc == PW'(SECOND_CYCLES - 1);

    // Access-time counters: address, selects, output enable
    for (genvar i = 0; i < 3; i++) begin : g_age
        localparam int THR = (i == 0) ? BCS_ADDR_CYC :
                             (i == 1) ? BCS_SEL_CYC : BCS_OE_CYC;
        logic [2:0] age;
        assign age_ok[i] = !restart[i] && age >= 3'(THR - 1);
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) age <= 3'h0;
            else if (restart[i]) age <= 3'h0;
            else if (age != 3'h7) age <= age + 3'h1;
        end
    end

    // Second prescaler; keeps running on battery
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc        <= '0;
            tick_q       <= 1'b0;
            ctrl_write_q <= 1'b0;
        end else begin
            presc        <= tick ? '0 : presc + PW'(1);
            tick_q       <= tick;
            ctrl_write_q <= write_hold;
        end
    end

    // Live calendar counters
    bcs_calendar u_cal (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .tick     (tick),
        .load     (cal_load),
        .ld_sec   (clock_cells[BCS_IDX_SEC]),
        .ld_min   (clock_cells[BCS_IDX_MIN]),
        .ld_hour  (clock_cells[BCS_IDX_HOUR]),
        .ld_day   (clock_cells[BCS_IDX_DAY]),
        .ld_date  (clock_cells[BCS_IDX_DATE]),
        .ld_month (clock_cells[BCS_IDX_MONTH]),
        .ld_year  (clock_cells[BCS_IDX_YEAR]),
        .sec      (cal_now[1]),
        .min      (cal_now[2]),
        .hour     (cal_now[3]),
        .day      (cal_now[4]),
        .date     (cal_now[5]),
        .month    (cal_now[6]),
        .year     (cal_now[7])
    );

    // Clock cells: refreshed from counters, host write wins a tie
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_cells[0] <= BCS_CTRL_RST;
            for (int k = 1; k < 8; k++) clock_cells[k] <= 8'h00;
        end else begin
            if (refresh) begin
                for (int k = 1; k < 8; k++) clock_cells[k] <= cal_now[k];
            end
            if (wr_en && clock_sel) clock_cells[cidx] <= data_io_in;
        end
    end

    // Main array write, blocked when power is out of tolerance
    always_ff @(posedge clk) begin
        if (wr_en && !clock_sel) mem[addr] <= data_io_in;
    end

    // Pin drivers and read data path
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_io_out   <= BCS_INDET_DATA;
            data_io_oe    <= 1'b0;
            data_io_valid <= 1'b0;
            deselected    <= 1'b1;
            prev_addr     <= '0;
        end else begin
            data_io_out   <= next_data;
            data_io_oe    <= rd_en;
            data_io_valid <= rd_en && all_ok;
            deselected    <= pf;
            prev_addr     <= addr;
        end
    end

    // Output data hold after an address change
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) hold_cnt <= 2'h0;
        else if (addr_chg && data_io_valid) hold_cnt <= 2'(BCS_HOLD_CYC - 1);
        else if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_float_idle: assert property (!rd_en |=> !data_io_oe)
        else $error("data lines driven while not selected for read");
    a_read_drive: assert property (rd_en |=> data_io_oe)
        else $error("read cycle did not drive the data lines");
    a_fail_protect: assert property ((pf && !clock_sel)
        ##1 $stable(addr) |-> rd_data == $past(rd_data))
        else $error("memory changed during power fail");
    a_fail_float: assert property (pf |=> !data_io_oe && deselected)
        else $error("outputs not floated in power fail");
    a_early_indet: assert property (rd_en && addr_chg |=>
        !data_io_valid)
        else $error("data marked valid before address access time");
    a_access_done: assert property ((rd_en && !addr_chg)[*4] |=>
        data_io_valid && data_io_out == $past(rd_data))
        else $error("read data not valid after access time");
    a_hold_data: assert property (addr_chg && data_io_valid && rd_en
        |=> data_io_out == $past(data_io_out))
        else $error("old data not held after address change");
    a_write_store: assert property (wr_en ##1 $stable(addr)
        |-> rd_data == $past(data_io_in))
        else $error("write data not stored");
    a_clock_map: assert property (clock_sel && rd_en && all_ok
        |=> data_io_out == $past(clock_cells[cidx]))
        else $error("clock byte not read at top locations");
    a_refresh_sec: assert property (refresh && !(wr_en && clock_sel)
        |=> clock_cells[1] == $past(cal_now[1]))
        else $error("clock cells not refreshed on tick");
    a_battery_count: assert property (on_battery && !tick
        |=> presc == $past(presc) + PW'(1))
        else $error("time base stopped on battery");

    c_read_valid: cover property (rd_en ##1 data_io_valid [*2]);
    c_write_mem: cover property (wr_en && !clock_sel);
    c_refresh: cover property (refresh);
    c_powerfail: cover property (pf && !select_active_low_n);
endmodule

/* File: testbench/bcs_host_model.sv */
// Purpose: Host processor model on the asynchronous memory bus.
// Assumes: Device outputs are registered on clk.
// Notes:   Bus changes only at falling edges; idle data lines toggle.
module bcs_host_model (
    // Clock
    input  wire logic                           clk,
    // Bus toward the device
    output logic [bcs_pkg::BCS_ADDR_W-1:0]      addr,
    output logic                                sel_lo_n,
    output logic                                sel_hi,
    output logic                                oe_n,
    output logic                                we_n,
    output logic [bcs_pkg::BCS_DATA_W-1:0]      data_in,
    // Answer from the device
    input  wire logic [bcs_pkg::BCS_DATA_W-1:0] data_out,
    input  wire logic                           data_oe,
    input  wire logic                           data_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wdata;
    logic [7:0] float_val;
    logic       drive;
    // Idle levels at time zero
    initial begin
        addr = '0;
        sel_lo_n = 1'b1;
        sel_hi = 1'b0;
        oe_n = 1'b1;
        we_n = 1'b1;
        drive = 1'b0;
        wdata = 8'h00;
        float_val = 8'h5A;
    end
    // Undriven lines change every cycle so no stale value survives
    always @(negedge clk) float_val <= ~float_val ^ 8'h3C;
    assign data_in = data_oe ? data_out : (drive ? wdata : float_val);
    // One write; output enable held high, address held for the cycle
    task automatic wr(input logic [12:0] a, input logic [7:0] dv,
                      input logic lo_n, input logic hi);
        @(negedge clk);
        addr = a;
        wdata = dv;
        drive = 1'b1;
        sel_lo_n = lo_n;
        sel_hi = hi;
        oe_n = 1'b1;
        we_n = 1'b0;
        @(negedge clk);
        we_n = 1'b1;
        sel_lo_n = 1'b1;
        sel_hi = 1'b0;
        drive = 1'b0;
    endtask
    // One read; holds until valid or 12 edges, then one idle cycle
    task automatic rd(input logic [12:0] a, input logic lo_n,
                      input logic hi, output logic [7:0] dv,
                      output int n, output logic seen);
        @(negedge clk);
        addr = a;
        sel_lo_n = lo_n;
        sel_hi = hi;
        oe_n = 1'b0;
        n = 0;
        seen = 1'b0;
        dv = 8'h00;
        while (n < 12) begin
            @(posedge clk);
            #1;
            n++;
            seen = seen | (data_oe === 1'b1);
            if (data_valid === 1'b1) break;
        end
        dv = data_out;
        @(negedge clk);
        sel_lo_n = 1'b1;
        sel_hi = 1'b0;
        oe_n = 1'b1;
        @(negedge clk);
    endtask
    // Read a1, then move to a2 with selects held, to see the output
    // hold and the filler value; this breaks address stability on purpose
    task automatic rd_move(input logic [12:0] a1, input logic [12:0] a2,
                           output logic [7:0] held,
                           output logic [7:0] indet,
                           output logic [7:0] dv);
        int n;
        @(negedge clk);
        addr = a1;
        sel_lo_n = 1'b0;
        sel_hi = 1'b1;
        oe_n = 1'b0;
        n = 0;
        while (n < 12 && data_valid !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        addr = a2;
        @(posedge clk);
        #1;
        held = data_out;
        @(posedge clk);
        #1;
        indet = data_out;
        n = 0;
        while (n < 12 && data_valid !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        dv = data_out;
        @(negedge clk);
        sel_lo_n = 1'b1;
        sel_hi = 1'b0;
        oe_n = 1'b1;
        @(negedge clk);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the clock-calendar memory.
// Assumes: Short second count; supply flags driven by the bench.
// Notes:   Reference memory is an associative array.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bcs_pkg::*;
    localparam int SEC_CYC = 64;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_ok = 1'b1;
    logic on_battery = 1'b0;
    logic [12:0] addr;
    logic sel_lo_n, sel_hi, oe_n, we_n, oe, valid, desel, seen;
    logic [7:0] din, dout, d, a8, hv, iv;
    logic [12:0] a;
    logic [31:0] rng = 32'h5F5B3354;
    logic [7:0] ref_mem [int];
    logic [7:0] cal [5][6];
    logic [3:0] mode [5];
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    always #12.5 clk = ~clk;
    bcs_clock_sram #(.SECOND_CYCLES(SEC_CYC)) bcs_clock_sram_inst (
        .clk(clk), .sys_rst(sys_rst), .addr(addr),
        .select_active_low_n(sel_lo_n), .select_active_high(sel_hi),
        .output_enable_n(oe_n), .write_enable_n(we_n),
        .data_io_in(din), .data_io_out(dout), .data_io_oe(oe),
        .data_io_valid(valid), .supply_ok(supply_ok),
        .on_battery(on_battery), .deselected(desel));
    bcs_host_model bcs_host_model_inst (
        .clk(clk), .addr(addr), .sel_lo_n(sel_lo_n), .sel_hi(sel_hi),
        .oe_n(oe_n), .we_n(we_n), .data_in(din), .data_out(dout),
        .data_oe(oe), .data_valid(valid));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic w(input logic [12:0] wa, input logic [7:0] wd,
                     input logic lo_n = 1'b0, input logic hi = 1'b1);
        bcs_host_model_inst.wr(wa, wd, lo_n, hi);
    endtask
    task automatic r(input logic [12:0] ra, input logic lo_n = 1'b0,
                     input logic hi = 1'b1);
        bcs_host_model_inst.rd(ra, lo_n, hi, d, n, seen);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        mode = '{4'b0110, 4'b1110, 4'b0010, 4'b0100, 4'b0111};
        cal = '{'{8'h00, 8'h02, 8'h28, 8'h29, 8'h02, 8'h00},
                '{8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01},
                '{8'h00, 8'h04, 8'h30, 8'h01, 8'h05, 8'h00},
                '{8'h99, 8'h12, 8'h31, 8'h01, 8'h01, 8'h00},
                '{8'h05, 8'h12, 8'h31, 8'h01, 8'h01, 8'h06}};
        repeat (16) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        r(BCS_CLOCK_BASE);
        chk(d, BCS_CTRL_RST, "ctrl reset");
        chk(8'(n), 8'd5, "read latency");
        w(BCS_CLOCK_BASE, 8'h25);
        r(BCS_CLOCK_BASE);
        chk(d, 8'h25, "calibration");
        $display("test reset and control done");
        // Random back-to-back writes then reads, with both array ends
        for (int i = 0; i < 32; i++) begin
            rng = xs(rng);
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FF7 : rng[12:0];
            if (a >= BCS_CLOCK_BASE) a = a - 13'h0010;
            ref_mem[a] = rng[20:13];
            w(a, rng[20:13]);
        end
        foreach (ref_mem[k]) begin
            r(13'(k));
            chk(d, ref_mem[k], "array data");
        end
        // Address move mid-read: old data held, then filler, then new
        bcs_host_model_inst.rd_move(13'h0000, 13'h1FF7, hv, iv, d);
        chk(hv, ref_mem[0], "old data hold");
        chk(iv, BCS_INDET_DATA, "indeterminate gap");
        chk(d, ref_mem[13'h1FF7], "moved read");
        $display("test array done");
        // Select and supply modes: only full select in tolerance works
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            {supply_ok, on_battery} = mode[i][1:0];
            w(13'h0100, 8'h40 + 8'(i), mode[i][3], mode[i][2]);
            if (i == 0) ref_mem[13'h0100] = 8'h40;
            r(13'h0100, mode[i][3], mode[i][2]);
            chk(8'(seen), 8'(i == 0), "drive enable");
            chk(8'(desel), 8'(i > 2), "deselect");
            @(negedge clk);
            {supply_ok, on_battery} = 2'b10;
            r(13'h0100);
            chk(d, ref_mem[13'h0100], "write block");
        end
        $display("test modes done");
        // Calendar rollover from 23:59:59 on day 7
        foreach (cal[c]) begin
            w(BCS_CLOCK_BASE, 8'h80);
            for (int j = 1; j < 8; j++) begin
                a8 = (j < 3) ? 8'h59 : (j == 3) ? 8'h23 : (j == 4) ?
                     8'h07 : cal[c][7-j];
                w(BCS_CLOCK_BASE + 13'(j), a8);
            end
            w(BCS_CLOCK_BASE, 8'h00);
            for (int k = 0; k < 60; k++) begin
                r(BCS_CLOCK_BASE + 13'h1);
                if (d === 8'h00) break;
            end
            w(BCS_CLOCK_BASE, 8'h40);
            for (int j = 1; j < 8; j++) begin
                r(BCS_CLOCK_BASE + 13'(j));
                a8 = (j < 4) ? 8'h00 : (j == 4) ? 8'h01 : cal[c][j-2];
                chk(d, a8, "calendar");
            end
            w(BCS_CLOCK_BASE, 8'h00);
        end
        $display("test calendar done");
        print_verdict();
    end
endmodule
